//--- dpc_cal_seq.sv
// Peak current monitor calibration sequencer
`timescale 1ns/1ps
module dpc_cal_seq
  import dpc_pkg::*;
#(
  parameter int CYCLES = CAL_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  output logic busy
);
  dpc_cal_state_t state;
  logic [31:0] count;
  wire run_done = (count == 32'(CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DPC_CAL_IDLE;
      count <= 32'h0;
      busy <= 1'b0;
    end else begin
      case (state)
        DPC_CAL_IDLE: begin
          count <= 32'h0;
          if (start) begin
            state <= DPC_CAL_RUN;
            busy <= 1'b1;
          end
        end
        DPC_CAL_RUN: begin
          count <= count + 32'h1;
          if (run_done) begin
            state <= DPC_CAL_DONE;
            busy <= 1'b0;
          end
        end
        DPC_CAL_DONE: state <= DPC_CAL_IDLE;
        default: begin
          state <= DPC_CAL_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- dpc_partner.sv
// Model of the external switching transistor and its peak current comparator
`timescale 1ns/1ps
module dpc_partner (
  // Clock
  input wire logic pclk,
  // Gate drive and trip limit in drive-high cycles, zero never trips
  input wire logic drive,
  input wire logic [7:0] trip_len,
  // Comparator output
  output logic trip
);
  logic [7:0] on_cnt = 8'h00;
  initial trip = 1'b0;
  always @(posedge pclk) begin
    on_cnt <= drive ? on_cnt + 8'h01 : 8'h00;
    trip <= (trip_len != 8'h00) && drive && (on_cnt >= trip_len);
  end
endmodule

//--- dpc_pkg.sv
// Shared constants for the converter PWM and current sense register block
package dpc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_XTOR_TWO = 8'h55;
  localparam logic [7:0] IDX_XTOR_THREE = 8'h56;
  localparam logic [7:0] IDX_XTOR_FOUR = 8'h57;
  localparam logic [7:0] IDX_XTOR_FIVE = 8'h58;
  localparam logic [7:0] IDX_XTOR_SIX = 8'h59;
  localparam logic [7:0] IDX_PWM_PERIOD = 8'h5C;
  localparam logic [7:0] IDX_SWITCH_DELAY = 8'h5D;
  localparam logic [7:0] IDX_PULSE_WIDTH = 8'h5E;
  localparam logic [7:0] IDX_BIAS_CTRL = 8'h5F;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PERIOD_RANGE_BIT = 7;
  localparam int PERIOD_FIXED_BIT = 6;
  localparam int CAL_BIT = 7;
  localparam int POL_BIT = 5;
  localparam int TOF_MSB = 4;
  localparam int BIAS_EN_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PERIOD_RESET = 8'h40;
  localparam logic [4:0] TOF_RESET = 5'h14;
  localparam logic [7:0] PERIOD_FIXED_MASK = 8'h40;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int TICK_PS = 61035;
  localparam logic [7:0] OFF_TIME_BIAS = 8'h04;
  localparam int CAL_TIME_US = 100;
  localparam int CAL_CYCLES = (CAL_TIME_US * 1000000) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // Calibration sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DPC_CAL_IDLE, DPC_CAL_RUN, DPC_CAL_DONE} dpc_cal_state_t;
endpackage

//--- dpc_pwm_core.sv
// PWM engine on a 61.035 ns tick derived from pclk
`timescale 1ns/1ps
module dpc_pwm_core
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and results
  dpc_pwm_if.core pwm
);
  // ----------------------------------------------------------------
  // Tick from a phase accumulator, average period 61.035 ns
  // ----------------------------------------------------------------
  logic [16:0] acc;
  wire [17:0] acc_sum = {1'b0, acc} + 18'(CLK_PERIOD_PS);
  wire tick = (acc_sum >= 18'(TICK_PS));
  wire [17:0] acc_wrap = acc_sum - 18'(TICK_PS);
  // ----------------------------------------------------------------
  // Period counter and on window
  // ----------------------------------------------------------------
  logic [7:0] cnt;
  logic [7:0] on_ticks;
  logic tripped;
  logic [7:0] off_ticks;
  wire [7:0] off_len = {3'h0, pwm.min_off_time_code} + OFF_TIME_BIAS;
  wire [7:0] on_limit = pwm.period_code - off_len;
  wire last_tick = (cnt == pwm.period_code - 8'h01);
  wire [7:0] next_cnt = last_tick ? 8'h00 : cnt + 8'h01;
  // Drive rises only at the period wrap and only after a full off time, so a setting
  // changed mid-period, a trip or a calibration can never cut the off time short
  wire on_now = (next_cnt < on_limit) && !pwm.cal_busy;
  wire off_ok = (off_ticks >= off_len - 8'h01);
  wire next_drive = last_tick ? (on_now && off_ok) : (on_now && pwm.switch_drive && !tripped);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 17'h0;
      cnt <= 8'h00;
      on_ticks <= 8'h00;
      tripped <= 1'b0;
      off_ticks <= 8'h00;
      pwm.switch_drive <= 1'b0;
      pwm.pulse_width_code <= 8'h00;
    end else begin
      acc <= tick ? acc_wrap[16:0] : acc_sum[16:0];
      if (pwm.peak_trip && pwm.switch_drive) begin
        tripped <= 1'b1;
        pwm.switch_drive <= 1'b0;
      end
      if (tick) begin
        cnt <= next_cnt;
        pwm.switch_drive <= next_drive;
        if (pwm.switch_drive) begin
          off_ticks <= 8'h00;
        end else if (off_ticks != 8'hFF) begin
          off_ticks <= off_ticks + 8'h01;
        end
        if (last_tick) begin
          tripped <= 1'b0;
          on_ticks <= 8'h00;
          pwm.pulse_width_code <= on_ticks + off_len;
        end else if (pwm.switch_drive) begin
          on_ticks <= on_ticks + 8'h01;
        end
      end
    end
  end
endmodule

//--- dpc_pwm_if.sv
// Carrier between the register file and the PWM engine
`timescale 1ns/1ps
interface dpc_pwm_if;
  logic [7:0] period_code;
  logic [4:0] min_off_time_code;
  logic cal_busy;
  logic peak_trip;
  logic switch_drive;
  logic [7:0] pulse_width_code;
  modport regs (output period_code, output min_off_time_code, output cal_busy, output peak_trip,
    input switch_drive, input pulse_width_code);
  modport core (input period_code, input min_off_time_code, input cal_busy, input peak_trip,
    output switch_drive, output pulse_width_code);
endinterface

//--- dpc_top.sv
// Converter PWM controls and transistor current monitor registers on APB
//
// Function
// - Transistor two current reads as 8-bit code, 0.319 mA per step.
// - With extended bias enabled, extra bias current is removed from the transistor two code.
// - Transistor three current reads as 8-bit code, 37.6 uA per step.
// - Transistor four current reads as 8-bit code, 37.6 uA per step.
// - Transistor five current reads as 8-bit code, 0.316 mA per step.
// - Transistor six current reads with the same scale as transistor five.
// - PWM period is the period code times 61.035 ns, codes 0x40 to 0xFF.
// - Period bit 6 always reads one; only bit 7 and bits 5:0 are writable.
// - Period bit 7 selects the short range or the long range.
// - Writing one to the calibration bit starts peak current monitor calibration.
// - Calibration bit reads one while calibration runs, zero otherwise.
// - Read-only polarity bit shows feed-forward versus drive polarity, fixed by variant.
// - Minimum off time is off-time code plus four, in 61.035 ns ticks.
// - Pulse width code reads on-time plus off-time code plus four, in ticks.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dpc_top
  import dpc_pkg::*;
#(
  parameter bit SAME_POLARITY = 1'b0,
  parameter int CAL_LEN = CAL_CYCLES
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Current monitor codes from the sense converter
  input wire logic [7:0] xtor_two_sense,
  input wire logic [7:0] xtor_three_sense,
  input wire logic [7:0] xtor_four_sense,
  input wire logic [7:0] xtor_five_sense,
  input wire logic [7:0] xtor_six_sense,
  input wire logic [7:0] extended_bias_current,
  // Peak current comparator
  input wire logic peak_current_trip,
  // Switching transistor drive
  output logic switch_drive_output,
  output logic feed_forward_output
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [31:0] addr, input logic [7:0] idx);
    addr_is = (addr == {22'h0, idx, 2'b00});
  endfunction

  wire hit_two = addr_is(paddr, IDX_XTOR_TWO);
  wire hit_three = addr_is(paddr, IDX_XTOR_THREE);
  wire hit_four = addr_is(paddr, IDX_XTOR_FOUR);
  wire hit_five = addr_is(paddr, IDX_XTOR_FIVE);
  wire hit_six = addr_is(paddr, IDX_XTOR_SIX);
  wire hit_period = addr_is(paddr, IDX_PWM_PERIOD);
  wire hit_delay = addr_is(paddr, IDX_SWITCH_DELAY);
  wire hit_width = addr_is(paddr, IDX_PULSE_WIDTH);
  wire hit_ctrl = addr_is(paddr, IDX_BIAS_CTRL);
  wire hit_any = hit_two | hit_three | hit_four | hit_five | hit_six | hit_period | hit_delay |
    hit_width | hit_ctrl;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 49;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  wire [SYNC_W-1:0] sync_in = {peak_current_trip, extended_bias_current, xtor_six_sense,
    xtor_five_sense, xtor_four_sense, xtor_three_sense, xtor_two_sense};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= sync_in;
      sync_b <= sync_a;
    end
  end

  wire [7:0] s_two = sync_b[7:0];
  wire [7:0] s_three = sync_b[15:8];
  wire [7:0] s_four = sync_b[23:16];
  wire [7:0] s_five = sync_b[31:24];
  wire [7:0] s_six = sync_b[39:32];
  wire [7:0] s_bias = sync_b[47:40];
  wire s_trip = sync_b[48];

  // ----------------------------------------------------------------
  // Software settings
  // ----------------------------------------------------------------
  logic [7:0] pwm_period_code;
  logic [4:0] min_off_time_code;
  logic extended_bias_enable;
  logic cal_start;
  logic cal_busy;

  wire wr_fire = psel & penable & pready & pwrite;
  wire wr_period = wr_fire & hit_period;
  wire wr_delay = wr_fire & hit_delay;
  wire wr_ctrl = wr_fire & hit_ctrl;
  wire [7:0] next_period = (pwdata[7:0] & ~PERIOD_FIXED_MASK) | PERIOD_FIXED_MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_period_code <= PERIOD_RESET;
      min_off_time_code <= TOF_RESET;
      extended_bias_enable <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      cal_start <= wr_delay & pwdata[CAL_BIT] & ~cal_busy;
      if (wr_period) begin
        pwm_period_code <= next_period;
      end
      if (wr_delay) begin
        min_off_time_code <= pwdata[TOF_MSB:0];
      end
      if (wr_ctrl) begin
        extended_bias_enable <= pwdata[BIAS_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration and PWM engine
  // ----------------------------------------------------------------
  dpc_cal_seq #(.CYCLES(CAL_LEN)) u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .start(cal_start),
    .busy(cal_busy)
  );

  dpc_pwm_if pwm_bus ();
  assign pwm_bus.period_code = pwm_period_code;
  assign pwm_bus.min_off_time_code = min_off_time_code;
  assign pwm_bus.cal_busy = cal_busy;
  assign pwm_bus.peak_trip = s_trip;

  dpc_pwm_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .pwm(pwm_bus.core)
  );

  // ----------------------------------------------------------------
  // Drive pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_drive_output <= 1'b0;
      feed_forward_output <= ~SAME_POLARITY;
    end else begin
      switch_drive_output <= pwm_bus.switch_drive;
      feed_forward_output <= SAME_POLARITY ? pwm_bus.switch_drive : ~pwm_bus.switch_drive;
    end
  end

  // ----------------------------------------------------------------
  // Current monitor codes
  // ----------------------------------------------------------------
  logic [7:0] xtor_two_current_code;
  logic [7:0] xtor_three_current_code;
  logic [7:0] xtor_four_current_code;
  logic [7:0] xtor_five_current_code;
  logic [7:0] xtor_six_current_code;

  wire [8:0] two_less_bias = {1'b0, s_two} - {1'b0, s_bias};
  wire [7:0] two_net = two_less_bias[8] ? 8'h00 : two_less_bias[7:0];
  wire [7:0] next_two = extended_bias_enable ? two_net : s_two;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtor_two_current_code <= 8'h00;
      xtor_three_current_code <= 8'h00;
      xtor_four_current_code <= 8'h00;
      xtor_five_current_code <= 8'h00;
      xtor_six_current_code <= 8'h00;
    end else begin
      xtor_two_current_code <= next_two;
      xtor_three_current_code <= s_three;
      xtor_four_current_code <= s_four;
      xtor_five_current_code <= s_five;
      xtor_six_current_code <= s_six;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  wire [7:0] delay_view = {cal_busy, 1'b0, SAME_POLARITY, min_off_time_code};
  wire [7:0] next_rdata =
    hit_two ? xtor_two_current_code :
    hit_three ? xtor_three_current_code :
    hit_four ? xtor_four_current_code :
    hit_five ? xtor_five_current_code :
    hit_six ? xtor_six_current_code :
    hit_period ? pwm_period_code :
    hit_delay ? delay_view :
    hit_width ? pwm_bus.pulse_width_code :
    hit_ctrl ? {7'h00, extended_bias_enable} : 8'h00;
  wire access = psel & penable & ~pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access & ~hit_any;
      prdata <= (access & ~pwrite) ? {24'h0, next_rdata} : 32'h0;
    end
  end
endmodule

//--- dpc_top_properties.sv
// Port assertions for the converter PWM register block
`timescale 1ns/1ps
module dpc_top_properties
  import dpc_pkg::*;
#(
  parameter bit SAME_POLARITY = 1'b0,
  parameter int CAL_LEN = CAL_CYCLES
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Drive pins
  input wire logic switch_drive_output,
  input wire logic feed_forward_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_hit = psel & penable & pready & !pwrite;
  wire wr_hit = psel & penable & pready & pwrite;
  logic [15:0] gap;
  logic rng, rng_prev;
  // Clocks since the last drive rise, and the range bit in force at that rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 16'hFFFF;
      rng <= 1'b0;
      rng_prev <= 1'b0;
    end else begin
      gap <= $rose(switch_drive_output) ? 16'h0001 : gap + {15'h0000, gap != 16'hFFFF};
      rng <= (wr_hit && paddr == 32'h00000170) ? pwdata[7] : rng;
      rng_prev <= $rose(switch_drive_output) ? rng : rng_prev;
    end
  end
  property p_fixed; rd_hit && paddr == 32'h00000170 |-> prdata[6]; endproperty
  a_fixed: assert property (p_fixed) else $error("period bit 6 low");
  property p_pol; rd_hit && paddr == 32'h00000174 |-> prdata[6:5] == {1'b0, SAME_POLARITY}; endproperty
  a_pol: assert property (p_pol) else $error("delay bits 6:5 wrong");
  property p_ff; feed_forward_output == (switch_drive_output ~^ SAME_POLARITY); endproperty
  a_ff: assert property (p_ff) else $error("feed-forward polarity wrong");
  property p_code; rd_hit && paddr inside {[32'h00000154:32'h00000164]} |-> prdata[31:8] == 24'h000000; endproperty
  a_code: assert property (p_code) else $error("current code wider than 8 bits");
  property p_cal; wr_hit && paddr == 32'h00000174 && pwdata[7] |-> ##10 !switch_drive_output [*8]; endproperty
  a_cal: assert property (p_cal) else $error("drive active during calibration");
  property p_off; $fell(switch_drive_output) |=> !switch_drive_output [*8]; endproperty
  a_off: assert property (p_off) else $error("off time too short");
  property p_gap; $rose(switch_drive_output) |-> gap >= 16'h00BE; endproperty
  a_gap: assert property (p_gap) else $error("period below 64 ticks");
  property p_long; $rose(switch_drive_output) && rng && rng_prev |-> gap >= 16'h0230; endproperty
  a_long: assert property (p_long) else $error("long range period too short");
endmodule
bind dpc_top dpc_top_properties #(.SAME_POLARITY(SAME_POLARITY), .CAL_LEN(CAL_LEN)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .switch_drive_output(switch_drive_output),
  .feed_forward_output(feed_forward_output));

//--- dpc_top_tb.sv
// Self-checking bench for the converter PWM register block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module dpc_top_tb
  import dpc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, x = 32'h00005E52;
  logic pready, pslverr, drive, ffo, trip;
  logic [7:0] sense [5] = '{default: 8'h00};
  logic [7:0] bias = 8'h00, trip_len = 8'h00;
  int err_total = 0, n_checks = 0;
  int mdl [int];
  int pt [3] = '{8'h40, 8'h80, 8'hFF};
  int tt [3] = '{8'h14, 8'h00, 8'h1F};
  dpc_top #(.CAL_LEN(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtor_two_sense(sense[0]), .xtor_three_sense(sense[1]), .xtor_four_sense(sense[2]),
    .xtor_five_sense(sense[3]), .xtor_six_sense(sense[4]), .extended_bias_current(bias),
    .peak_current_trip(trip), .switch_drive_output(drive), .feed_forward_output(ffo));
  dpc_partner xtor_u (.pclk(pclk), .drive(drive), .trip_len(trip_len), .trip(trip));
  initial forever #10 pclk = ~pclk;
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic bit near(int c, int ticks);
    return (c - ticks * TICK_PS / CLK_PERIOD_PS) inside {[-2:2]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic ee, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk) n++; while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    r = prdata;
    `CHK(pslverr, ee)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, i, d, 1'b0, r);
    if (i == IDX_PWM_PERIOD) mdl[i] = d[7:0] | 8'h40;
    if (i == IDX_SWITCH_DELAY) mdl[i] = d[4:0];
    if (i == IDX_BIAS_CTRL) mdl[i] = d[0];
  endtask
  task automatic rchk(input logic [7:0] i, input int ex);
    logic [31:0] r;
    apb(1'b0, i, 32'h0, 1'b0, r);
    `CHK(r, 32'(ex))
  endtask
  // Skips to the next rise, then counts high and low clocks of one period
  task automatic meas(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (drive !== 1'b0 && lo < 2000) @(posedge pclk) lo++;
    while (drive !== 1'b1 && lo < 4000) @(posedge pclk) lo++;
    lo = 0;
    while (drive === 1'b1 && hi < 900) @(posedge pclk) hi++;
    while (drive === 1'b0 && lo < 900) @(posedge pclk) lo++;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    int hi, lo, p, b;
    logic [31:0] r;
    mdl = '{IDX_PWM_PERIOD: 8'h40, IDX_SWITCH_DELAY: 8'h14, IDX_BIAS_CTRL: 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (mdl[i]) rchk(8'(i), mdl[i]);
    for (int k = 0; k < 6; k++) begin
      foreach (sense[j]) sense[j] <= 8'(rnd());
      bias <= 8'(rnd());
      wr(IDX_BIAS_CTRL, 32'(k % 2));
      wr(IDX_XTOR_TWO, rnd());
      wr(IDX_PWM_PERIOD, rnd());
      rchk(IDX_PWM_PERIOD, mdl[IDX_PWM_PERIOD]);
      b = (mdl[IDX_BIAS_CTRL] == 1) ? bias : 0;
      foreach (sense[j]) rchk(8'(IDX_XTOR_TWO + j), j > 0 ? sense[j] : sense[0] > b ? sense[0] - b : 0);
    end
    apb(1'b1, 8'h5A, 32'hFFFFFFFF, 1'b1, r);
    apb(1'b0, 8'h5A, 32'h0, 1'b1, r);
    `CHK(r, 32'h0)
    foreach (pt[i]) begin
      wr(IDX_PWM_PERIOD, pt[i]);
      wr(IDX_SWITCH_DELAY, tt[i]);
      p = mdl[IDX_PWM_PERIOD];
      meas(hi, lo);
      meas(hi, lo);
      `CHK(near(hi, p - tt[i] - 4) && near(lo, tt[i] + 4), 1'b1)
      rchk(IDX_PULSE_WIDTH, p);
    end
    trip_len <= 8'h1E;
    meas(hi, lo);
    meas(hi, lo);
    `CHK(hi < 40 && lo > 600, 1'b1)
    apb(1'b0, IDX_PULSE_WIDTH, 32'h0, 1'b0, r);
    `CHK(r > 35 && r < 60, 1'b1)
    trip_len <= 8'h00;
    wr(IDX_SWITCH_DELAY, 8'h94);
    rchk(IDX_SWITCH_DELAY, 8'h94);
    repeat (30) @(posedge pclk);
    rchk(IDX_SWITCH_DELAY, mdl[IDX_SWITCH_DELAY]);
    give_verdict();
  end
endmodule
